// >>> cfe_fanout_ctrl.sv
// Top of the clock fanout enable and power-down controller.
// Assumes pins and reference are asynchronous to clk and pass two flops; the reference
// is sampled as a level and must be well below half of clk for a clean copy.
// How it works
// - Eight outputs, each register and pin enabled
// - Register enables active high, reset enabled
// - Output runs when pin low and bit
// - Disabled pair parks both legs low
// - Pin falling restarts output without glitch
// - Pin rising stops output without glitch
// - Strap picks 100/133, output follows input
// - First power-good rise latches the straps
// - Afterwards pin low means power down
// - Two comp rising edges low, then stop
// - Three-level strap picks PLL bandwidth mode
// - Off until supply good, then delay
// - Wait for reference and power good
// - Outputs enabled only after PLL lock
// - Power-on to outputs below 1.8 ms
// - No reference keeps outputs disabled
// - Byte 0 bit 7 reads PLL mode
`timescale 1ns/1ps
`default_nettype none
module cfe_fanout_ctrl
	import cfe_pkg::*;
#(
	parameter int NUM_OUT = CFE_NUM_OUT,
	parameter int DELAY_CYC = CFE_DELAY_CYC,
	parameter int STAB_CYC = CFE_STAB_CYC,
	parameter logic [7:0] ID_VALUE = 8'h5A // Arbitrary identity value.
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic refClk,
	input wire logic supplyGood,
	input wire logic pllLock,
	input wire logic refValid,
	input wire logic power_good_sleep_n,
	input wire logic [NUM_OUT-1:0] outEnablePin_n,
	input wire logic freq_select_strap,
	input wire logic [1:0] pll_bandwidth_strap,
	input wire logic [1:0] bus_address_straps,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic [NUM_OUT-1:0] clock_out_true,
	output logic [NUM_OUT-1:0] clock_out_comp,
	output logic freqSel133_n,
	output logic [1:0] pllMode,
	output logic [1:0] busAddress,
	output logic outputsRunning
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_OUT-1:0] oeS1;
		logic [NUM_OUT-1:0] oeS2;
		logic pgS1;
		logic pgS2;
		logic spS1;
		logic spS2;
		logic lkS1;
		logic lkS2;
		logic rvS1;
		logic rvS2;
		logic rcS1;
		logic rcS2;
		logic rcDly;
		logic fsS1;
		logic fsS2;
		logic [1:0] bwS1;
		logic [1:0] bwS2;
		logic [1:0] saS1;
		logic [1:0] saS2;
		logic strapped;
		logic freqSel;
		logic [1:0] bwMode;
		logic [1:0] addr;
		logic [NUM_OUT-1:0] oeBits;
		logic [1:0] lowEdges;
		logic sleeping;
		logic [31:0] dlyCnt;
		cfe_pwr_e pwr;
		logic [7:0] rdata;
	} cfe_top_s;
	cfe_top_s state_reg;
	cfe_top_s state_next;
	logic [NUM_OUT-1:0] gateEnable;

	// Synchronised reference falls: complementary leg rises.
	function automatic logic compRise(input logic now, input logic dly);
		compRise = dly & ~now;
	endfunction : compRise

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		state_next.oeS1 = outEnablePin_n;
		state_next.oeS2 = state_reg.oeS1;
		state_next.pgS1 = power_good_sleep_n;
		state_next.pgS2 = state_reg.pgS1;
		state_next.spS1 = supplyGood;
		state_next.spS2 = state_reg.spS1;
		state_next.lkS1 = pllLock;
		state_next.lkS2 = state_reg.lkS1;
		state_next.rvS1 = refValid;
		state_next.rvS2 = state_reg.rvS1;
		state_next.rcS1 = refClk;
		state_next.rcS2 = state_reg.rcS1;
		state_next.rcDly = state_reg.rcS2;
		// Straps pass two flops like the other pins; the sequencer holds them still before power good.
		state_next.fsS1 = freq_select_strap;
		state_next.fsS2 = state_reg.fsS1;
		state_next.bwS1 = pll_bandwidth_strap;
		state_next.bwS2 = state_reg.bwS1;
		state_next.saS1 = bus_address_straps;
		state_next.saS2 = state_reg.saS1;

		// Straps are caught once, on the first power-good high.
		if (!state_reg.strapped && state_reg.pgS2)
		begin
			state_next.strapped = 1'b1;
			state_next.freqSel = state_reg.fsS2;
			state_next.bwMode = state_reg.bwS2;
			state_next.addr = state_reg.saS2;
		end

		// Power-down counts low samples on complementary rising edges.
		if (state_reg.pgS2)
		begin
			state_next.lowEdges = '0;
			state_next.sleeping = 1'b0;
		end
		else if (state_reg.strapped && compRise(state_reg.rcS2, state_reg.rcDly))
		begin
			if (state_reg.lowEdges < 2'(CFE_PD_EDGES))
			begin
				state_next.lowEdges = state_reg.lowEdges + 2'h1;
			end
		end
		// Enables drop two cycles after the second low sample, inside the reference low phase,
		// so every gate stops at the following comp high-to-low, which is the reference rise.
		if (!state_reg.pgS2 && state_reg.lowEdges == 2'(CFE_PD_EDGES))
		begin
			state_next.sleeping = 1'b1;
		end

		unique case (state_reg.pwr)
			CFE_ST_OFF:
			begin
				state_next.dlyCnt = '0;
				if (state_reg.spS2)
				begin
					state_next.pwr = CFE_ST_DELAY;
				end
			end
			CFE_ST_DELAY:
			begin
				state_next.dlyCnt = state_reg.dlyCnt + 32'h1;
				if (state_reg.dlyCnt >= 32'(DELAY_CYC - 1))
				begin
					state_next.pwr = CFE_ST_WAIT;
				end
			end
			CFE_ST_WAIT:
			begin
				// Lock is required too, so a missing reference keeps outputs off.
				if (state_reg.rvS2 && state_reg.pgS2 && state_reg.lkS2)
				begin
					state_next.pwr = CFE_ST_RUN;
				end
			end
			CFE_ST_RUN:
			begin
				if (!state_reg.rvS2 || !state_reg.lkS2)
				begin
					state_next.pwr = CFE_ST_WAIT;
				end
			end
		endcase
		if (!state_reg.spS2)
		begin
			state_next.pwr = CFE_ST_OFF;
		end

		// Register access; reserved and identity bytes ignore writes.
		if (regWrite && regAddr == CFE_ADDR_OE)
		begin
			state_next.oeBits = regWdata[NUM_OUT-1:0];
		end
		if (regRead)
		begin
			unique case (regAddr)
				CFE_ADDR_MODE:
				begin
					state_next.rdata = CFE_ZERO_BYTE;
					state_next.rdata[CFE_MODE_RD_BIT] = state_reg.bwMode == CFE_PLL_BYPASS;
					state_next.rdata[1:0] = state_reg.bwMode;
					state_next.rdata[2] = state_reg.freqSel;
				end
				CFE_ADDR_OE: state_next.rdata = 8'(state_reg.oeBits);
				CFE_ADDR_RSVD: state_next.rdata = CFE_ZERO_BYTE;
				CFE_ADDR_ID: state_next.rdata = ID_VALUE;
				default: state_next.rdata = CFE_ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= '0;
			state_reg.oeBits <= CFE_OE_RESET[NUM_OUT-1:0];
			state_reg.oeS1 <= '1;
			state_reg.oeS2 <= '1;
		end
		else if (clkEn)
		begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Output gating
	// ----------------------------------------------------------------
	assign outputsRunning = state_reg.pwr == CFE_ST_RUN && !state_reg.sleeping;
	assign gateEnable = ~state_reg.oeS2 & state_reg.oeBits & {NUM_OUT{outputsRunning}};

	for (genvar i = 0; i < NUM_OUT; i++)
	begin : gOut
		cfe_out_gate uGate (
			.clk(clk),
			.rstn(rstn),
			.clkEn(clkEn),
			.refClk(state_reg.rcS2),
			.enable(gateEnable[i]),
			.outTrue(clock_out_true[i]),
			.outComp(clock_out_comp[i])
		);
	end

	assign regRdata = state_reg.rdata;
	assign freqSel133_n = state_reg.freqSel;
	assign pllMode = state_reg.bwMode;
	assign busAddress = state_reg.addr;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Start-up time is counted only while reference, lock and power good are all present.
	logic [31:0] upCnt;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			upCnt <= '0;
		else if (state_reg.pwr == CFE_ST_OFF || state_reg.pwr == CFE_ST_RUN)
			upCnt <= '0;
		else if (clkEn && state_reg.rvS2 && state_reg.lkS2 && state_reg.pgS2)
			upCnt <= upCnt + 32'h1;
	end

	a_run_needs_lock: assert property (@(posedge clk) disable iff (!rstn)
		$rose(state_reg.pwr == CFE_ST_RUN) |-> $past(state_reg.lkS2)) else $error("run without lock");
	a_oe_reset_on: assert property (@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> state_reg.oeBits == CFE_OE_RESET[NUM_OUT-1:0]) else $error("enables not reset on");
	a_gate_and: assert property (@(posedge clk) disable iff (!rstn)
		gateEnable[0] |-> !state_reg.oeS2[0] && state_reg.oeBits[0]) else $error("gate ignores pin or bit");
	a_sleep_stops: assert property (@(posedge clk) disable iff (!rstn)
		state_reg.sleeping && state_reg.rcS2 && !state_reg.rcDly |=> clock_out_true == '0 && clock_out_comp == '0)
		else $error("outputs not stopped");
	a_sleep_cause: assert property (@(posedge clk) disable iff (!rstn)
		$rose(state_reg.sleeping) |-> state_reg.lowEdges == 2'(CFE_PD_EDGES)) else $error("early sleep");
	a_straps_once: assert property (@(posedge clk) disable iff (!rstn)
		state_reg.strapped |=> $stable(state_reg.bwMode) && $stable(state_reg.freqSel)) else $error("straps moved");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
		regRead && regAddr == CFE_ADDR_RSVD |=> regRdata == CFE_ZERO_BYTE) else $error("reserved byte nonzero");
	a_delay_least: assert property (@(posedge clk) disable iff (!rstn)
		$rose(state_reg.pwr == CFE_ST_WAIT) && $past(state_reg.pwr) == CFE_ST_DELAY
		|-> $past(state_reg.dlyCnt) >= 32'(DELAY_CYC - 1)) else $error("delay too short");
	a_stab_bound: assert property (@(posedge clk) disable iff (!rstn)
		upCnt < 32'(STAB_CYC)) else $error("power-up too slow");
	a_no_ref_off: assert property (@(posedge clk) disable iff (!rstn)
		!state_reg.rvS2 |=> !outputsRunning) else $error("running without reference");

	c_run: cover property (@(posedge clk) disable iff (!rstn) $rose(outputsRunning));
	c_sleep: cover property (@(posedge clk) disable iff (!rstn) $rose(state_reg.sleeping));
	c_wake: cover property (@(posedge clk) disable iff (!rstn) $fell(state_reg.sleeping));
	c_pin_off: cover property (@(posedge clk) disable iff (!rstn) outputsRunning && state_reg.oeS2[0]);
endmodule : cfe_fanout_ctrl
`default_nettype wire

// >>> cfe_fanout_ctrl_test.sv
// Self-checking bench for the fanout enable and power-down controller.
// Assumes cfe_partner supplies the reference, lock and supply detection.
`timescale 1ns/1ps
`default_nettype none
module cfe_fanout_ctrl_test import cfe_pkg::*;;
	// ----------------
	// Stimulus and checks
	// ----------------
	logic clk, rstn, supplyOn, refRun, refClk, refValid, pllLock, supplyGood, power_good_sleep_n, fs;
	logic regWrite, regRead, freqSel133_n, outputsRunning, prevT, prevR;
	logic [1:0] bw, sa, pllMode, busAddress;
	logic [2:0] regAddr;
	logic [7:0] pinN, regWdata, regRdata, outT, outC, acc, cmp, v;
	int err_total = 0, n_compared = 0, cyc = 0, runts = 0, hiLen = 0, nT = 0, nR = 0, k, a, b;
	cfe_partner i_cfe_partner (.clk(clk), .supplyOn(supplyOn), .refRun(refRun), .refClk(refClk),
		.refValid(refValid), .pllLock(pllLock), .supplyGood(supplyGood));
	// Identity value is arbitrary.
	cfe_fanout_ctrl #(.DELAY_CYC(20), .STAB_CYC(200), .ID_VALUE(8'h3C)) i_cfe_fanout_ctrl (.clk(clk),
		.rstn(rstn), .clkEn(1'b1), .refClk(refClk), .supplyGood(supplyGood), .pllLock(pllLock),
		.refValid(refValid), .power_good_sleep_n(power_good_sleep_n), .outEnablePin_n(pinN),
		.freq_select_strap(fs), .pll_bandwidth_strap(bw), .bus_address_straps(sa), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.clock_out_true(outT), .clock_out_comp(outC), .freqSel133_n(freqSel133_n), .pllMode(pllMode),
		.busAddress(busAddress), .outputsRunning(outputsRunning));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// A high phase shorter than most of a reference half period would be a runt.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		prevT <= outT[0];
		prevR <= refClk;
		if (outT[0] && !prevT) nT <= nT + 1;
		if (refClk && !prevR) nR <= nR + 1;
		hiLen <= outT[3] ? hiLen + 1 : 0;
		if (!outT[3] && hiLen != 0 && hiLen < 4) runts <= runts + 1;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= ad;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] ad, output logic [7:0] d);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= ad;
		@(posedge clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask : rd
	task automatic sample(input int n);
		acc = 8'h00;
		cmp = 8'hFF;
		repeat (n)
		begin
			@(posedge clk);
			#1 acc |= outT | outC;
			cmp &= outT ^ outC;
		end
	endtask : sample
	task automatic pwrUp(input logic [1:0] m, input logic f, input logic [1:0] s, input bit noRef);
		@(posedge clk);
		rstn <= 1'b0;
		power_good_sleep_n <= 1'b0;
		supplyOn <= 1'b0;
		refRun <= 1'b0;
		{bw, fs, sa} <= {m, f, s};
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		supplyOn <= 1'b1;
		refRun <= !noRef;
		repeat (6) @(posedge clk);
		power_good_sleep_n <= 1'b1;
		k = 6;
		if (noRef)
		begin
			repeat (150) @(posedge clk);
			chk({outputsRunning, outT[6:0]}, 8'h00);
			refRun <= 1'b1;
			k += 150;
		end
		while (outputsRunning !== 1'b1 && k < 300)
		begin
			@(posedge clk);
			#1 k++;
		end
		chk({7'h0, k >= 20 && k < 200}, 8'h01);
		chk({3'h0, freqSel133_n, pllMode, busAddress}, {3'h0, f, m, s});
		rd(3'h0, v);
		chk(v & 8'h87, {m == CFE_PLL_BYPASS, 4'h0, f, m});
		$display("test powerup mode %h done", m);
	endtask : pwrUp
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	initial
	begin
		{rstn, supplyOn, refRun, power_good_sleep_n, fs, regWrite, regRead} = 7'h00;
		{bw, sa, regAddr, pinN, regWdata} = 23'h0;
		pwrUp(CFE_PLL_LBW, 1'b1, 2'h1, 1'b1);
		pwrUp(CFE_PLL_BYPASS, 1'b0, 2'h2, 1'b0);
		pwrUp(CFE_PLL_HBW, 1'b1, 2'h3, 1'b0);
		rd(3'h1, v);
		chk(v, 8'hFF);
		wr(3'h4, 8'hFF);
		rd(3'h4, v);
		chk(v, 8'h00);
		rd(3'h5, v);
		chk(v, 8'h3C);
		rd(3'h7, v);
		chk(v, 8'h00);
		wr(3'h0, 8'h00);
		rd(3'h0, v);
		chk(v & 8'h87, 8'h06);
		$display("test registers done");
		sample(40);
		chk(acc, 8'hFF);
		chk(cmp, 8'hFF);
		pinN[3] <= 1'b1;
		wr(3'h1, 8'hDF);
		repeat (30) @(posedge clk);
		sample(40);
		chk(acc, 8'hD7);
		pinN[3] <= 1'b0;
		wr(3'h1, 8'hFF);
		repeat (30) @(posedge clk);
		sample(40);
		chk(acc, 8'hFF);
		a = nT;
		b = nR;
		repeat (400) @(posedge clk);
		k = (nT - a) - (nR - b);
		chk({7'h0, k >= -1 && k <= 1}, 8'h01);
		$display("test enables done");
		fs <= 1'b0;
		power_good_sleep_n <= 1'b0;
		repeat (50) @(posedge clk);
		sample(40);
		chk({outputsRunning, acc[6:0]}, 8'h00);
		power_good_sleep_n <= 1'b1;
		repeat (50) @(posedge clk);
		sample(40);
		chk(acc, 8'hFF);
		chk({7'h0, freqSel133_n}, 8'h01);
		power_good_sleep_n <= 1'b0;
		repeat (50) @(posedge clk);
		refRun <= 1'b0;
		sample(40);
		chk(acc, 8'h00);
		chk(runts[7:0], 8'h00);
		$display("test power-down done");
		summarize();
	end
endmodule : cfe_fanout_ctrl_test
`default_nettype wire

// >>> cfe_out_gate.sv
// Per-output glitch-free gate, one instance per differential pair.
// Assumes refClk is the free-running reference and enable is already synchronous to it.
`timescale 1ns/1ps
`default_nettype none
module cfe_out_gate
	import cfe_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic refClk,
	input wire logic enable,
	output logic outTrue,
	output logic outComp
);
	typedef struct packed {
		logic refDly;
		logic gateOn;
		logic outT;
		logic outC;
	} cfe_gate_s;
	cfe_gate_s state_reg;
	cfe_gate_s state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.refDly = refClk;
		// Gate moves only as the reference rises: the true leg then starts or skips a whole high phase
		// and the comp leg ends its high phase on time, so neither leg can leave a runt.
		if (refClk && !state_reg.refDly)
		begin
			state_next.gateOn = enable;
		end
		state_next.outT = state_next.gateOn & refClk;
		state_next.outC = state_next.gateOn & ~refClk;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= '0;
		end
		else if (clkEn)
		begin
			state_reg <= state_next;
		end
	end

	assign outTrue = state_reg.outT;
	assign outComp = state_reg.outC;

	a_park_low: assert property (@(posedge clk) disable iff (!rstn)
		!state_reg.gateOn |-> !(state_reg.outT | state_reg.outC)) else $error("parked pair not low");
endmodule : cfe_out_gate
`default_nettype wire

// >>> cfe_partner.sv
// Far-side model: supply detector, reference source and PLL lock.
// Assumes clk is the system clock; outputs change just after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module cfe_partner
	import cfe_pkg::*;
#(
	parameter int HALF_CYC = 5,
	parameter int LOCK_CYC = 16
)
(
	input wire logic clk,
	input wire logic supplyOn,
	input wire logic refRun,
	output logic refClk,
	output logic refValid,
	output logic pllLock,
	output logic supplyGood
);
	int divCnt = 0;
	int lockCnt = 0;
	int supCnt = 0;
	initial
	begin
		refClk = 1'b0;
		refValid = 1'b0;
		pllLock = 1'b0;
		supplyGood = 1'b0;
	end
	// The reference stands low while stopped, as a halted synthesizer would.
	always @(posedge clk)
	begin
		divCnt <= (refRun && divCnt < HALF_CYC - 1) ? divCnt + 1 : 0;
		if (!refRun)
			refClk <= 1'b0;
		else if (divCnt == HALF_CYC - 1)
			refClk <= ~refClk;
		refValid <= refRun;
		lockCnt <= refRun ? lockCnt + 1 : 0;
		pllLock <= refRun && lockCnt >= LOCK_CYC;
		supCnt <= supplyOn ? supCnt + 1 : 0;
		supplyGood <= supplyOn && supCnt >= 3;
	end
endmodule : cfe_partner
`default_nettype wire

// >>> cfe_pkg.sv
// Package for the clock fanout enable and power-down control block.
// Assumes a single 125 MHz system clock and byte-wide management registers.
package cfe_pkg;
	localparam int CFE_NUM_OUT = 8;
	localparam int CFE_CLK_MHZ = 125;
	// Supply-good delay window, in microseconds; the least time is used.
	localparam int CFE_DELAY_MIN_US = 100;
	localparam int CFE_DELAY_CYC = CFE_DELAY_MIN_US * CFE_CLK_MHZ;
	// Bound on power-on to outputs active, in microseconds.
	localparam int CFE_STAB_MAX_US = 1800;
	localparam int CFE_STAB_CYC = CFE_STAB_MAX_US * CFE_CLK_MHZ;
	localparam logic [2:0] CFE_ADDR_MODE = 3'h0;
	localparam logic [2:0] CFE_ADDR_OE = 3'h1;
	localparam logic [2:0] CFE_ADDR_RSVD = 3'h4;
	localparam logic [2:0] CFE_ADDR_ID = 3'h5;
	localparam int CFE_MODE_RD_BIT = 7;
	localparam logic [7:0] CFE_OE_RESET = 8'hFF;
	localparam logic [7:0] CFE_ZERO_BYTE = 8'h00;
	localparam int CFE_PD_EDGES = 2;
	typedef enum logic [1:0] {
		CFE_PLL_LBW = 2'b00,
		CFE_PLL_BYPASS = 2'b01,
		CFE_PLL_HBW = 2'b10
	} cfe_bw_e;
	typedef enum logic [1:0] {
		CFE_ST_OFF = 2'b00,
		CFE_ST_DELAY = 2'b01,
		CFE_ST_WAIT = 2'b10,
		CFE_ST_RUN = 2'b11
	} cfe_pwr_e;
endpackage : cfe_pkg
